//--- src/cable_diag_and_loopback.sv
// reflectometry sequencer, cable length pass-through and loopback muxing
// assumes mode bits arrive as plain ports from the management register file
module cable_diag_and_loopback
    import cable_diag_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    // mode bits from the management registers
    input wire logic tdr_enable,
    input wire logic manual_pair_select,
    input wire logic near_loop_enable,
    input wire logic analog_loop_enable,
    input wire logic [cable_diag_pkg::CBL_W-1:0] cable_length_code,
    input wire logic link_100_up,
    // status toward the management registers
    output logic tdr_done,
    output logic tdr_fault_seen,
    output logic [cable_diag_pkg::LEN_W-1:0] tdr_channel_length,
    output logic [cable_diag_pkg::CBL_W-1:0] cable_length_report,
    output logic cable_length_valid,
    output logic link_force_down,
    // analog front end
    output logic pulse_tx_pair,
    output logic pulse_rx_pair,
    input wire logic reflection_seen,
    output logic line_tx_power_on,
    // mac side
    input wire logic mac_tx_en,
    input wire logic [1:0] mac_txd,
    output logic mac_crs_dv,
    output logic [1:0] mac_rxd,
    // coded stream toward and from the line
    output logic line_tx_en,
    output logic [1:0] line_txd,
    input wire logic line_rx_dv,
    input wire logic [1:0] line_rxd
);
    import cable_diag_pkg::*;

    typedef struct packed {
        tdr_state_type st;
        logic [CNT_W-1:0] cnt;
        logic [LEN_W-1:0] len;
        logic done;
        logic fault;
        logic pair_rx;
        logic [CBL_W-1:0] cbl;
        logic cbl_ok;
        logic rx_dv;
        logic [1:0] rxd;
        logic tx_en;
        logic [1:0] txd;
    } state_type;

    state_type r;
    state_type next_r;
    logic tick;
    logic [5:0] div;

    ////////////////////////////////////////////////////////////////////////////
    // length tick: window split into one step per length code
    // at 25 MHz a step is a single cycle, so div rests at zero
    always_ff @(posedge core_clk) begin
        if (rst || r.st != ST_LISTEN || tick) begin
            div <= 6'h00;
        end else begin
            div <= div + 6'h01;
        end
    end
    assign tick = (div == 6'(TDR_WINDOW_CYC / (2 ** LEN_W) - 1));

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_r = r;
        next_r.cbl = cable_length_code;
        next_r.cbl_ok = link_100_up;
        case (r.st)
            ST_IDLE: begin
                if (tdr_enable) begin
                    next_r.st = ST_SETTLE;
                    next_r.done = 1'b0;
                    next_r.fault = 1'b0;
                    next_r.len = LEN_ZERO;
                    next_r.cnt = CNT_ZERO;
                    // crossover forced off, so the manual select decides
                    next_r.pair_rx = manual_pair_select;
                end
            end
            ST_SETTLE: begin
                // give the dropped link time to go quiet before pulsing
                next_r.cnt = r.cnt + CNT_ONE;
                if (r.cnt == CNT_W'(TDR_SETTLE_CYC - 1)) begin
                    next_r.st = ST_PULSE;
                    next_r.cnt = CNT_ZERO;
                end
            end
            ST_PULSE: begin
                next_r.cnt = r.cnt + CNT_ONE;
                if (r.cnt == CNT_W'(TDR_PULSE_CYC - 1)) begin
                    next_r.st = ST_LISTEN;
                    next_r.cnt = CNT_ZERO;
                end
            end
            ST_LISTEN: begin
                if (reflection_seen) begin
                    next_r.st = ST_IDLE;
                    next_r.fault = 1'b1;
                    next_r.done = 1'b1;
                end else if (r.len == LEN_MAX && tick) begin
                    // matched cable: no echo, length left meaningless
                    next_r.st = ST_IDLE;
                    next_r.done = 1'b1;
                end else if (tick) begin
                    next_r.len = r.len + 8'h01;
                end
            end
            default: next_r.st = ST_IDLE;
        endcase
        if (!tdr_enable) begin
            next_r.st = ST_IDLE;
        end
        // far loop: line data turned straight back to the line
        if (analog_loop_enable) begin
            next_r.tx_en = line_rx_dv;
            next_r.txd = line_rxd;
            next_r.rx_dv = 1'b0;
            next_r.rxd = DIBIT_ZERO;
        end else if (near_loop_enable) begin
            // turned around past the coding stages, one register of delay
            next_r.rx_dv = mac_tx_en;
            next_r.rxd = mac_txd;
            next_r.tx_en = mac_tx_en;
            next_r.txd = mac_txd;
        end else begin
            next_r.rx_dv = line_rx_dv;
            next_r.rxd = line_rxd;
            next_r.tx_en = mac_tx_en;
            next_r.txd = mac_txd;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            r <= '{st: ST_IDLE, cnt: CNT_ZERO, len: LEN_ZERO, done: 1'b0, fault: 1'b0,
                   pair_rx: 1'b0, cbl: CBL_ZERO, cbl_ok: 1'b0, rx_dv: 1'b0,
                   rxd: DIBIT_ZERO, tx_en: 1'b0, txd: DIBIT_ZERO};
        end else begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign tdr_done = r.done;
    assign tdr_fault_seen = r.fault;
    assign tdr_channel_length = r.len;
    assign cable_length_report = r.cbl;
    assign cable_length_valid = r.cbl_ok;
    assign link_force_down = tdr_enable;
    assign pulse_tx_pair = (r.st == ST_PULSE) && !r.pair_rx;
    assign pulse_rx_pair = (r.st == ST_PULSE) && r.pair_rx;
    // near loop never lights the line, whatever the mac does
    assign line_tx_power_on = !near_loop_enable && !tdr_enable;
    assign mac_crs_dv = r.rx_dv;
    assign mac_rxd = r.rxd;
    assign line_tx_en = r.tx_en && !near_loop_enable;
    assign line_txd = near_loop_enable ? DIBIT_ZERO : r.txd;

    ////////////////////////////////////////////////////////////////////////////
    pulse_pair_sel_a: assert property (@(posedge core_clk) disable iff (rst)
        (r.st == ST_IDLE && tdr_enable) |=> (r.pair_rx == $past(manual_pair_select)))
        else $error("tested pair not taken from manual select");
    // ten settle cycles split into two short runs; pulse seen on the eleventh edge
    pulse_after_settle_a: assert property (@(posedge core_clk) disable iff (rst)
        (r.st == ST_IDLE && tdr_enable) ##1 tdr_enable [*8] ##1 tdr_enable [*2]
        |=> (pulse_tx_pair || pulse_rx_pair))
        else $error("pulse not sent after settle time");
    pulse_one_pair_a: assert property (@(posedge core_clk) disable iff (rst)
        !(pulse_tx_pair && pulse_rx_pair))
        else $error("pulse on both pairs");
    echo_done_a: assert property (@(posedge core_clk) disable iff (rst)
        (r.st == ST_LISTEN && reflection_seen && tdr_enable) |=> (tdr_done && tdr_fault_seen))
        else $error("echo did not finish the test");
    // enable left high restarts the test, so only an idle, disabled block must hold
    length_hold_a: assert property (@(posedge core_clk) disable iff (rst)
        (tdr_done && r.st == ST_IDLE && !tdr_enable) |=> $stable(tdr_channel_length))
        else $error("length moved after completion");
    link_drop_a: assert property (@(posedge core_clk) disable iff (rst)
        tdr_enable |-> (link_force_down && !line_tx_power_on))
        else $error("link not dropped during test");
    near_loop_a: assert property (@(posedge core_clk) disable iff (rst)
        (near_loop_enable && !analog_loop_enable) |=> (mac_rxd == $past(mac_txd)))
        else $error("near loop data not returned");
    near_quiet_a: assert property (@(posedge core_clk) disable iff (rst)
        near_loop_enable |-> (!line_tx_power_on && !line_tx_en))
        else $error("line driven in near loop");
    far_loop_a: assert property (@(posedge core_clk) disable iff (rst)
        analog_loop_enable ##1 (analog_loop_enable && !near_loop_enable)
        |-> (line_txd == $past(line_rxd) && !mac_crs_dv))
        else $error("far loop not looping or not isolated");
    cable_valid_a: assert property (@(posedge core_clk) disable iff (rst)
        cable_length_valid |-> $past(link_100_up))
        else $error("cable length valid without link");

    cover_fault_c: cover property (@(posedge core_clk) disable iff (rst) $rose(tdr_fault_seen));
    cover_match_c: cover property (@(posedge core_clk) disable iff (rst)
        $rose(tdr_done) && !tdr_fault_seen);
    cover_rx_pair_c: cover property (@(posedge core_clk) disable iff (rst) pulse_rx_pair);
    cover_far_c: cover property (@(posedge core_clk) disable iff (rst)
        analog_loop_enable && line_tx_en);
endmodule

//--- src/cable_diag_pkg.sv
// constants for the cable diagnostic and loopback block
// assumes one 25 MHz core clock and synchronous active-high reset
package cable_diag_pkg;
    localparam int CLK_MHZ = 25;
    // reflectometry timing, in ns
    localparam int TDR_SETTLE_NS = 400;
    localparam int TDR_SETTLE_CYC = (TDR_SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int TDR_PULSE_NS = 80;
    localparam int TDR_PULSE_CYC = (TDR_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int TDR_WINDOW_NS = 10240;
    localparam int TDR_WINDOW_CYC = TDR_WINDOW_NS * CLK_MHZ / 1000;
    localparam int LEN_W = 8;
    localparam int CBL_W = 4;
    localparam int CNT_W = 9;
    localparam logic [LEN_W-1:0] LEN_ZERO = 8'h00;
    localparam logic [LEN_W-1:0] LEN_MAX = 8'hFF;
    localparam logic [CBL_W-1:0] CBL_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ZERO = 9'h000;
    localparam logic [CNT_W-1:0] CNT_ONE = 9'h001;
    localparam logic [1:0] DIBIT_ZERO = 2'h0;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SETTLE = 2'b01,
        ST_PULSE = 2'b10,
        ST_LISTEN = 2'b11
    } tdr_state_type;
endpackage

//--- verif/cable_diag_and_loopback_tb.sv
// self-checking bench for reflectometry, cable length and both loopbacks
// assumes the partner model answers pulses; mode bits are driven as ports
module cable_diag_and_loopback_tb;
    import cable_diag_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0, rst = 1'b1, tdr_enable = 1'b0, manual_pair_select = 1'b0;
    logic near_loop_enable = 1'b0, analog_loop_enable = 1'b0, link_100_up = 1'b0;
    logic [3:0] cable_length_code = 4'h0;
    logic tdr_done, tdr_fault_seen, cable_length_valid, link_force_down;
    logic [7:0] tdr_channel_length;
    logic [3:0] cable_length_report;
    logic pulse_tx_pair, pulse_rx_pair, reflection_seen, line_tx_power_on;
    logic mac_tx_en = 1'b0, line_rx_dv = 1'b0, mac_crs_dv, line_tx_en;
    logic [1:0] mac_txd = 2'h0, line_rxd = 2'h0, mac_rxd, line_txd;
    logic [15:0] echo_delay = 16'h0000;
    int n_mismatch = 0, total_checks = 0;
    always #20 core_clk = ~core_clk;
    ////////////////////////////////////////////////////////////////////////////////
    cable_diag_and_loopback i_cable_diag_and_loopback (.core_clk(core_clk), .rst(rst),
        .tdr_enable(tdr_enable), .manual_pair_select(manual_pair_select),
        .near_loop_enable(near_loop_enable), .analog_loop_enable(analog_loop_enable),
        .cable_length_code(cable_length_code), .link_100_up(link_100_up),
        .tdr_done(tdr_done), .tdr_fault_seen(tdr_fault_seen),
        .tdr_channel_length(tdr_channel_length), .cable_length_report(cable_length_report),
        .cable_length_valid(cable_length_valid), .link_force_down(link_force_down),
        .pulse_tx_pair(pulse_tx_pair), .pulse_rx_pair(pulse_rx_pair),
        .reflection_seen(reflection_seen), .line_tx_power_on(line_tx_power_on),
        .mac_tx_en(mac_tx_en), .mac_txd(mac_txd), .mac_crs_dv(mac_crs_dv), .mac_rxd(mac_rxd),
        .line_tx_en(line_tx_en), .line_txd(line_txd), .line_rx_dv(line_rx_dv),
        .line_rxd(line_rxd));
    cable_partner i_cable_partner (.core_clk(core_clk), .pulse_tx_pair(pulse_tx_pair),
        .pulse_rx_pair(pulse_rx_pair), .echo_delay(echo_delay),
        .reflection_seen(reflection_seen));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // modes first, then enable; enable dropped once done is seen
    task automatic run_tdr(input logic pair, input logic [15:0] echo, input logic [7:0] len,
                           input logic flt);
        int n;
        manual_pair_select = pair;
        echo_delay = echo;
        @(negedge core_clk);
        tdr_enable = 1'b1;
        @(negedge core_clk);
        chk("force_down", 8'(link_force_down), 8'h01);
        chk("done_clear", 8'(tdr_done), 8'h00);
        n = 0;
        while (!(pulse_tx_pair | pulse_rx_pair) && n < 50) begin
            @(negedge core_clk);
            n++;
        end
        chk("pulse_tx", 8'(pulse_tx_pair), 8'(!pair));
        chk("pulse_rx", 8'(pulse_rx_pair), 8'(pair));
        n = 0;
        while (tdr_done !== 1'b1 && n < 12000) begin
            @(negedge core_clk);
            n++;
        end
        tdr_enable = 1'b0;
        chk("done", 8'(tdr_done), 8'h01);
        chk("fault", 8'(tdr_fault_seen), 8'(flt));
        chk("length", tdr_channel_length, len);
        @(negedge core_clk);
        chk("done_hold", 8'(tdr_done), 8'h01);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // watchdog sized for one full no-echo window plus the short tests
    initial begin
        #(40 * 30000);
        n_mismatch++;
        final_report();
    end
    initial begin
        repeat (16) @(negedge core_clk);
        rst = 1'b0;
        chk("reset_done", 8'(tdr_done), 8'h00);
        // one length step per cycle, so the echo delay is the expected length
        run_tdr(1'b0, 16'd100, 8'h64, 1'b1);
        run_tdr(1'b1, 16'd200, 8'hC8, 1'b1);
        run_tdr(1'b1, 16'h0000, LEN_MAX, 1'b0);
        manual_pair_select = 1'b0;
        // abort in mid-test: link released, done stays cleared by the start
        tdr_enable = 1'b1;
        repeat (5) @(negedge core_clk);
        tdr_enable = 1'b0;
        @(negedge core_clk);
        chk("abort_link", 8'(link_force_down), 8'h00);
        chk("abort_done", 8'(tdr_done), 8'h00);
        for (int i = 0; i < 16; i++) begin
            cable_length_code = 4'(i);
            link_100_up = i[0];
            @(negedge core_clk);
            chk("cbl_code", 8'(cable_length_report), 8'(i));
            chk("cbl_valid", 8'(cable_length_valid), 8'(i[0]));
        end
        near_loop_enable = 1'b1;
        for (int i = 0; i < 4; i++) begin
            mac_tx_en = 1'b1;
            mac_txd = 2'(i);
            @(negedge core_clk);
            chk("near_rxd", 8'(mac_rxd), 8'(i));
            chk("near_dv", 8'(mac_crs_dv), 8'h01);
            chk("near_txen", 8'(line_tx_en), 8'h00);
            chk("near_power", 8'(line_tx_power_on), 8'h00);
        end
        near_loop_enable = 1'b0;
        analog_loop_enable = 1'b1;
        for (int i = 0; i < 4; i++) begin
            line_rx_dv = 1'b1;
            line_rxd = 2'(3 - i);
            @(negedge core_clk);
            chk("far_txd", 8'(line_txd), 8'(3 - i));
            chk("far_txen", 8'(line_tx_en), 8'h01);
            chk("far_mac_dv", 8'(mac_crs_dv), 8'h00);
            chk("far_mac_rxd", 8'(mac_rxd), 8'h00);
        end
        final_report();
    end
endmodule

//--- verif/cable_partner.sv
// cable and link partner model: echoes test pulses back as a reflection
// assumes pulses come from the block's pulse outputs on core_clk
module cable_partner (
    input wire logic core_clk,
    input wire logic pulse_tx_pair,
    input wire logic pulse_rx_pair,
    input wire logic [15:0] echo_delay,
    output logic reflection_seen
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] count = 16'h0000;
    initial reflection_seen = 1'b0;
    ////////////////////////////////////////////////////////////////////////////////
    // a delay of zero models a matched cable, which never reflects
    always @(posedge core_clk) begin
        if (pulse_tx_pair || pulse_rx_pair) begin
            count <= 16'h0001;
        end else if (count != 16'h0000 && count != 16'hFFFF) begin
            count <= count + 16'h0001;
        end
        reflection_seen <= (echo_delay != 16'h0000) && (count == echo_delay);
    end
endmodule
